// ==== vrc_params.svh ====
// Command encodings, field positions and timing counts of the voice command port.
`ifndef VRC_PARAMS_SVH
`define VRC_PARAMS_SVH

// ==========================================================================
// Command word layout
`define VRC_CMD_W 16
`define VRC_OP_HI 15
`define VRC_OP_LO 10
`define VRC_VOICE_W 10
`define VRC_OP_DELETE 6'h04
`define VRC_OP_CAPTURE 6'h08
`define VRC_OP_PLAY 6'h0c
`define VRC_WORD_STOP 16'h0000
`define VRC_WORD_WAKE 16'hb100
`define VRC_WORD_SLEEP 16'hb200
`define VRC_WORD_FORMAT 16'ha5a5

// ==========================================================================
// Timing
`define VRC_CLK_NS 5
`define VRC_BEEP_NS 1000
`define VRC_BEEP_CYC ((`VRC_BEEP_NS + `VRC_CLK_NS - 1) / `VRC_CLK_NS)
`define VRC_OP_CYC 64

`endif

// ==== vrc_pkg.sv ====
// Types shared by the voice command port.
package vrc_pkg;

	// ======================================================================
	// Sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CAPTURE = 3'b001,
		ST_PLAY = 3'b010,
		ST_DELETE = 3'b011,
		ST_FORMAT = 3'b100,
		ST_SLEEPING = 3'b101,
		ST_ASLEEP = 3'b110,
		ST_WAKING = 3'b111
	} vrc_state_type;

	// ======================================================================
	// A received command word with its strobe.
	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} vrc_cmd_type;

	// Status from the audio and memory engine.
	typedef struct packed {
		logic mem_full;
		logic voice_end;
	} vrc_engine_type;

endpackage : vrc_pkg

// ==== vrc_shift_rx.sv ====
// Serial receiver that assembles 16-bit command words.
`timescale 1ns/1ps
`include "vrc_params.svh"

module vrc_shift_rx (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Serial pins, asynchronous
	input wire logic cs_n,
	input wire logic sck,
	input wire logic serial_cmd_in,
	// Decoded word
	output vrc_pkg::vrc_cmd_type cmd
);

	// ======================================================================
	// Three-stage synchronisers; stage one feeds only stage two.
	logic [2:0] cs_s_q;
	logic [2:0] sck_s_q;
	logic [2:0] sdi_s_q;
	logic cs_lvl_q;
	logic sck_lvl_q;

	// The select and clock inputs are taken as stable once stages two and three agree.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cs_s_q <= 3'h7;
			sck_s_q <= 3'h0;
			sdi_s_q <= 3'h0;
			cs_lvl_q <= 1'b1;
			sck_lvl_q <= 1'b0;
		end else begin
			cs_s_q <= {cs_s_q[1:0], cs_n};
			sck_s_q <= {sck_s_q[1:0], sck};
			sdi_s_q <= {sdi_s_q[1:0], serial_cmd_in};
			if (cs_s_q[1] == cs_s_q[2]) begin
				cs_lvl_q <= cs_s_q[2];
			end
			if (sck_s_q[1] == sck_s_q[2]) begin
				sck_lvl_q <= sck_s_q[2];
			end
		end
	end

	// A filtered low-to-high change of the serial clock.
	logic sck_rise;
	assign sck_rise = (sck_s_q[1] == sck_s_q[2]) && sck_s_q[2] && !sck_lvl_q;

	// ======================================================================
	// Shift register and bit count.
	logic [15:0] shift_q;
	logic [4:0] count_q;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			shift_q <= 16'h0000;
			count_q <= 5'h00;
		end else if (cs_lvl_q) begin
			count_q <= 5'h00;
		end else if (sck_rise && count_q != 5'h10) begin
			shift_q <= {shift_q[14:0], sdi_s_q[2]};
			count_q <= count_q + 5'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cmd <= '0;
		end else begin
			cmd.valid <= !cs_lvl_q && sck_rise && count_q == 5'h0f;
			cmd.word <= {shift_q[14:0], sdi_s_q[2]};
		end
	end

endmodule : vrc_shift_rx

// ==== vrc_voice_port.sv ====
// Voice recorder command port: serial receiver plus operation sequencer.
`timescale 1ns/1ps
`include "vrc_params.svh"

module vrc_voice_port #(
	parameter int VOICES = 1024,
	parameter int OP_CYC = `VRC_OP_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Standby reset pin, active low, asynchronous
	input wire logic ext_standby_reset_n,
	// Serial command pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic serial_cmd_in,
	// Engine status, same clock domain
	input wire vrc_pkg::vrc_engine_type engine,
	// Feedback to host
	output logic serial_resp_out,
	output logic busy_n,
	// Engine controls
	output logic capture_en,
	output logic play_en,
	output logic beep
);

	// ======================================================================
	// Parameter checks, refused at elaboration.
	// The slot flags are indexed by the 10-bit voice field, so only 1024 fits.
	if (VOICES != 1024) begin : g_bad_voices
		$error("VOICES must match the 10-bit voice field");
	end
	// The operation timer is 16 bits wide and needs at least one cycle.
	if (OP_CYC < 1 || OP_CYC > 65535) begin : g_bad_op_cyc
		$error("OP_CYC out of range");
	end

	localparam logic [15:0] OP_LAST = 16'(OP_CYC - 1);
	localparam logic [15:0] BEEP_LAST = 16'(`VRC_BEEP_CYC - 1);

	// ======================================================================
	// Standby reset synchroniser; second and third stage must agree.
	logic [2:0] rst_s_q;
	logic run_q;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rst_s_q <= 3'h0;
			run_q <= 1'b0;
		end else begin
			rst_s_q <= {rst_s_q[1:0], ext_standby_reset_n};
			if (rst_s_q[1] == rst_s_q[2]) begin
				run_q <= rst_s_q[2];
			end
		end
	end

	// Local reset: chip reset or standby.
	logic lrst_n;
	assign lrst_n = rstn && run_q;

	// ======================================================================
	// Receiver.
	vrc_pkg::vrc_cmd_type cmd;

	vrc_shift_rx u_rx (
		.ref_clk(ref_clk),
		.rstn(lrst_n),
		.cs_n(cs_n),
		.sck(sck),
		.serial_cmd_in(serial_cmd_in),
		.cmd(cmd)
	);

	// ======================================================================
	// Decode.
	logic [5:0] op;
	logic [9:0] voice;
	logic is_stop, is_wake, is_sleep, is_format, is_del, is_cap, is_play;

	assign op = cmd.word[`VRC_OP_HI:`VRC_OP_LO];
	assign voice = cmd.word[`VRC_VOICE_W-1:0];
	assign is_stop = cmd.valid && cmd.word == `VRC_WORD_STOP;
	assign is_wake = cmd.valid && cmd.word == `VRC_WORD_WAKE;
	assign is_sleep = cmd.valid && cmd.word == `VRC_WORD_SLEEP;
	assign is_format = cmd.valid && cmd.word == `VRC_WORD_FORMAT;
	assign is_del = cmd.valid && op == `VRC_OP_DELETE;
	assign is_cap = cmd.valid && op == `VRC_OP_CAPTURE;
	assign is_play = cmd.valid && op == `VRC_OP_PLAY;

	// ======================================================================
	// Slot occupancy, one flag per voice.
	logic [VOICES-1:0] used_q;
	logic [9:0] slot_q;
	logic [15:0] timer_q;
	vrc_pkg::vrc_state_type state_q;
	logic timer_done;
	assign timer_done = timer_q == OP_LAST;

	for (genvar i = 0; i < VOICES; i++) begin : g_slot
		always_ff @(posedge ref_clk) begin
			if (!lrst_n) begin
				used_q[i] <= 1'b0;
			end else if (state_q == vrc_pkg::ST_FORMAT && timer_done) begin
				used_q[i] <= 1'b0;
			end else if (state_q == vrc_pkg::ST_DELETE && timer_done && slot_q == 10'(i)) begin
				used_q[i] <= 1'b0;
			end else if (state_q == vrc_pkg::ST_IDLE && is_cap && voice == 10'(i)
					&& !used_q[i] && !engine.mem_full) begin
				used_q[i] <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Sequencer. Storage is not modelled non-volatile: standby clears slots.
	always_ff @(posedge ref_clk) begin
		if (!lrst_n) begin
			state_q <= vrc_pkg::ST_IDLE;
			slot_q <= 10'h000;
		end else begin
			unique case (state_q)
				vrc_pkg::ST_IDLE: begin
					if (is_cap && !used_q[voice] && !engine.mem_full) begin
						state_q <= vrc_pkg::ST_CAPTURE;
						slot_q <= voice;
					end else if (is_play && used_q[voice]) begin
						state_q <= vrc_pkg::ST_PLAY;
						slot_q <= voice;
					end else if (is_del) begin
						state_q <= vrc_pkg::ST_DELETE;
						slot_q <= voice;
					end else if (is_format) begin
						state_q <= vrc_pkg::ST_FORMAT;
					end else if (is_sleep) begin
						state_q <= vrc_pkg::ST_SLEEPING;
					end
				end
				vrc_pkg::ST_CAPTURE: begin
					if (is_stop || engine.mem_full) begin
						state_q <= vrc_pkg::ST_IDLE;
					end
				end
				vrc_pkg::ST_PLAY: begin
					if (is_stop || engine.voice_end) begin
						state_q <= vrc_pkg::ST_IDLE;
					end
				end
				vrc_pkg::ST_DELETE, vrc_pkg::ST_FORMAT: begin
					if (timer_done) begin
						state_q <= vrc_pkg::ST_IDLE;
					end
				end
				vrc_pkg::ST_SLEEPING: begin
					if (timer_done) begin
						state_q <= vrc_pkg::ST_ASLEEP;
					end
				end
				vrc_pkg::ST_ASLEEP: begin
					if (is_wake) begin
						state_q <= vrc_pkg::ST_WAKING;
					end
				end
				vrc_pkg::ST_WAKING: begin
					if (timer_done) begin
						state_q <= vrc_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Operation timer for the timed states.
	always_ff @(posedge ref_clk) begin
		if (!lrst_n) begin
			timer_q <= 16'h0000;
		end else if (state_q == vrc_pkg::ST_IDLE || state_q == vrc_pkg::ST_ASLEEP
				|| state_q == vrc_pkg::ST_CAPTURE || state_q == vrc_pkg::ST_PLAY
				|| timer_done) begin
			timer_q <= 16'h0000;
		end else begin
			timer_q <= timer_q + 16'h0001;
		end
	end

	// ======================================================================
	// Beep generator: pulse count of tones pending, each BEEP_CYC long with gap.
	logic [1:0] beeps_q;
	logic [15:0] beep_t_q;
	logic gap_q;
	logic cap_start, cap_end;
	assign cap_start = state_q == vrc_pkg::ST_IDLE && is_cap && !used_q[voice]
		&& !engine.mem_full;
	assign cap_end = state_q == vrc_pkg::ST_CAPTURE && (is_stop || engine.mem_full);

	always_ff @(posedge ref_clk) begin
		if (!rstn || !run_q) begin
			beeps_q <= 2'h1;
			beep_t_q <= 16'h0000;
			gap_q <= 1'b0;
			beep <= 1'b0;
		end else if (cap_start) begin
			beeps_q <= 2'h1;
			beep_t_q <= 16'h0000;
			gap_q <= 1'b0;
			beep <= 1'b0;
		end else if (cap_end) begin
			beeps_q <= 2'h2;
			beep_t_q <= 16'h0000;
			gap_q <= 1'b0;
			beep <= 1'b0;
		end else if (beeps_q != 2'h0) begin
			beep <= !gap_q;
			if (beep_t_q == BEEP_LAST) begin
				beep_t_q <= 16'h0000;
				gap_q <= !gap_q;
				if (gap_q) begin
					beeps_q <= beeps_q - 2'h1;
				end
			end else begin
				beep_t_q <= beep_t_q + 16'h0001;
			end
		end else begin
			beep <= 1'b0;
		end
	end

	// ======================================================================
	// Registered outputs.
	// busy low on start
	always_ff @(posedge ref_clk) begin
		if (!lrst_n) begin
			busy_n <= 1'b1;
			capture_en <= 1'b0;
			play_en <= 1'b0;
			serial_resp_out <= 1'b0;
		end else begin
			busy_n <= state_q == vrc_pkg::ST_IDLE || state_q == vrc_pkg::ST_ASLEEP;
			capture_en <= state_q == vrc_pkg::ST_CAPTURE;
			play_en <= state_q == vrc_pkg::ST_PLAY;
			serial_resp_out <= 1'b0;
		end
	end

endmodule : vrc_voice_port

// ==== vrc_voice_port_assertions.sv ====
// Property checker for the voice command port outputs.
`timescale 1ns/1ps
module vrc_voice_port_assertions #(
	parameter int OP_CYC = 64
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Inputs
	input wire logic ext_standby_reset_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic serial_cmd_in,
	input wire vrc_pkg::vrc_engine_type engine,
	// Outputs
	input wire logic serial_resp_out,
	input wire logic busy_n,
	input wire logic capture_en,
	input wire logic play_en,
	input wire logic beep
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	int unsigned low_q;
	int unsigned tone_q;
	// ======================================================================
	// Run lengths; record and play are left out because only a stop word, the engine or a reset or standby ends them.
	always_ff @(posedge ref_clk) begin
		if (!rstn || busy_n || capture_en || play_en) begin
			low_q <= 0;
		end else begin
			low_q <= low_q + 1;
		end
	end
	// Tone length, so a stuck tone shows up.
	always_ff @(posedge ref_clk) begin
		if (!rstn || !beep) begin
			tone_q <= 0;
		end else begin
			tone_q <= tone_q + 1;
		end
	end
	// ======================================================================
	// Properties.
	AST_RESET_QUIET: assert property ($rose(rstn) |-> busy_n && !capture_en && !play_en)
		else $error("outputs not idle after reset");
	AST_CAPTURE_BUSY: assert property (capture_en |-> !busy_n)
		else $error("busy released while recording");
	AST_PLAY_BUSY: assert property (play_en |-> !busy_n)
		else $error("busy released while playing");
	AST_ONE_ACTIVE: assert property (!(capture_en && play_en))
		else $error("record and play at once");
	AST_CAPTURE_BEEP: assert property ($rose(capture_en) |-> ##[0:2] beep)
		else $error("no tone at record start");
	AST_FULL_ENDS: assert property (capture_en && engine.mem_full |-> ##[1:3] !capture_en && busy_n)
		else $error("full memory did not end recording");
	AST_VOICE_END: assert property (play_en && engine.voice_end |-> ##[1:3] !play_en && busy_n)
		else $error("voice end did not end playback");
	AST_STANDBY: assert property (!ext_standby_reset_n [*8] |-> busy_n && !capture_en && !beep)
		else $error("activity during standby");
	AST_OP_BOUNDED: assert property (low_q <= OP_CYC + 2)
		else $error("fixed operation held busy too long");
	AST_TONE_LEN: assert property (tone_q <= 200)
		else $error("tone longer than expected");
	AST_RESP_LOW: assert property (serial_resp_out == 1'b0)
		else $error("serial response not low");
endmodule : vrc_voice_port_assertions

// ==== vrc_host_model.sv ====
// Behavioural host that shifts command words into the voice port.
`timescale 1ns/1ps
module vrc_host_model #(
	parameter int HALF_NS = 32,
	parameter int SEL_NS = 100
) (
	// Clock
	input wire logic ref_clk,
	// Serial pins
	output logic cs_n,
	output logic sck,
	output logic serial_cmd_in
);
	// Idle pins; the serial clock stands low outside frames.
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		serial_cmd_in = 1'b1;
	end
	// ======================================================================
	// Sends the top nbits of word; a short count leaves a partial frame.
	// With sel low the select stays high while the bits are clocked.
	// msb first
	task automatic send(input logic [15:0] word, input int nbits, input logic sel);
		@(posedge ref_clk);
		#1;
		cs_n = !sel;
		// The extra half ns keeps every later pin change off a rising ref_clk edge.
		#(SEL_NS + 0.5);
		for (int i = 15; i > 15 - nbits; i--) begin
			serial_cmd_in = word[i];
			#(HALF_NS);
			sck = 1'b1;
			#(HALF_NS);
			sck = 1'b0;
		end
		#(HALF_NS);
		cs_n = 1'b1;
		// A released line flips so a stale bit cannot pass as held.
		serial_cmd_in = ~serial_cmd_in;
		#(HALF_NS);
		// Hand back just after a clock edge, where the bench drives its inputs.
		@(posedge ref_clk);
		#1;
	endtask : send
endmodule : vrc_host_model

// ==== tb_voice_record_command_port.sv ====
// Self-checking bench for the voice command port.
`timescale 1ns/1ps
module tb_voice_record_command_port;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic ext_standby_reset_n = 1'b1;
	vrc_pkg::vrc_engine_type engine = '0;
	logic cs_n, sck, serial_cmd_in, serial_resp_out, busy_n, capture_en, play_en, beep;
	int failures = 0;
	int compares = 0;
	logic [15:0] unk [4] = '{16'hffff, 16'hb300, 16'h0000, 16'h7000};

	// ======================================================================
	// Clock, host and design.
	always #2.5 ref_clk = ~ref_clk;
	vrc_host_model u_host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck),
		.serial_cmd_in(serial_cmd_in));
	vrc_voice_port #(.VOICES(1024), .OP_CYC(64)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
		.ext_standby_reset_n(ext_standby_reset_n), .cs_n(cs_n), .sck(sck),
		.serial_cmd_in(serial_cmd_in), .engine(engine), .serial_resp_out(serial_resp_out),
		.busy_n(busy_n), .capture_en(capture_en), .play_en(play_en), .beep(beep));

	// ======================================================================
	// Compare tasks, one per kind of result.
	task automatic check1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check1
	task automatic check_n(input int got, input int exp);
		compares++;
		if (got != exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_n
	task automatic conclude();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude
	// Ends each wait just after an edge, where inputs change and outputs are settled.
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	// Bounded wait for busy; running out is a mismatch and ends the run.
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy_n !== lvl && n < 300) begin
			cyc(1);
			n++;
		end
		check1(busy_n, lvl);
		if (busy_n !== lvl) begin
			conclude();
		end
	endtask : wait_busy
	// A refused word must never pull busy low.
	task automatic stays_idle();
		logic seen;
		seen = 1'b0;
		repeat (100) begin
			cyc(1);
			seen = seen | (busy_n !== 1'b1);
		end
		check1(seen, 1'b0);
	endtask : stays_idle
	// Counts tone starts; a tone already sounding counts too.
	task automatic beeps(output int n);
		logic p;
		p = 1'b0;
		n = 0;
		repeat (700) begin
			cyc(1);
			n += (beep === 1'b1 && !p);
			p = beep;
		end
	endtask : beeps
	task automatic cmd(input logic [15:0] w);
		u_host.send(w, 16, 1'b1);
	endtask : cmd
	function automatic logic [15:0] mk(input logic [5:0] op, input logic [9:0] v);
		return {op, v};
	endfunction : mk

	// ======================================================================
	// Main sequence.
	initial begin
		logic [9:0] v;
		logic [9:0] v2;
		int n;
		n = $urandom(83796);
		v = 10'h3ff;
		v2 = 10'($urandom % 1023);
		cyc(5);
		rstn = 1'b1;
		cyc(600);
		// record at top slot, ignore others, stop.
		cmd(mk(6'h08, v));
		wait_busy(1'b0);
		check1(capture_en, 1'b1);
		beeps(n);
		check_n(n, 1);
		cmd(mk(6'h0c, v));
		cmd(16'ha5a5);
		check1(play_en, 1'b0);
		check1(busy_n, 1'b0);
		cmd(16'h0000);
		wait_busy(1'b1);
		check1(capture_en, 1'b0);
		beeps(n);
		check_n(n, 2);
		cmd(mk(6'h08, v));
		stays_idle();
		// play, ignore delete, end of voice, empty slot.
		cmd(mk(6'h0c, v));
		wait_busy(1'b0);
		check1(play_en, 1'b1);
		cmd(mk(6'h04, v));
		check1(play_en, 1'b1);
		engine.voice_end = 1'b1;
		wait_busy(1'b1);
		engine.voice_end = 1'b0;
		check1(play_en, 1'b0);
		cmd(mk(6'h0c, v2));
		stays_idle();
		cmd(mk(6'h04, v));
		wait_busy(1'b0);
		wait_busy(1'b1);
		cmd(mk(6'h0c, v));
		stays_idle();
		// full memory ends and refuses recording.
		cmd(mk(6'h08, v2));
		wait_busy(1'b0);
		engine.mem_full = 1'b1;
		wait_busy(1'b1);
		check1(capture_en, 1'b0);
		cmd(mk(6'h08, v));
		stays_idle();
		engine.mem_full = 1'b0;
		cmd(16'ha5a5);
		wait_busy(1'b0);
		wait_busy(1'b1);
		cmd(mk(6'h0c, v2));
		stays_idle();
		cmd(16'hb200);
		wait_busy(1'b0);
		wait_busy(1'b1);
		cmd(mk(6'h08, v));
		stays_idle();
		cmd(16'hb100);
		wait_busy(1'b0);
		wait_busy(1'b1);
		cmd(mk(6'h08, v));
		wait_busy(1'b0);
		cmd(16'h0000);
		wait_busy(1'b1);
		// a stop word ends playback of the slot just recorded.
		cmd(mk(6'h0c, v));
		wait_busy(1'b0);
		cmd(16'h0000);
		wait_busy(1'b1);
		check1(play_en, 1'b0);
		// partial frame, unselected clocks, idle stop and unknown words.
		u_host.send(mk(6'h08, v2), 15, 1'b1);
		stays_idle();
		u_host.send(mk(6'h08, v2), 16, 1'b0);
		stays_idle();
		foreach (unk[i]) begin
			cmd(unk[i]);
			stays_idle();
		end
		// standby aborts recording, release beeps once.
		cmd(mk(6'h08, v2));
		wait_busy(1'b0);
		ext_standby_reset_n = 1'b0;
		cyc(10);
		check1(busy_n, 1'b1);
		check1(capture_en, 1'b0);
		ext_standby_reset_n = 1'b1;
		beeps(n);
		check_n(n, 1);
		conclude();
	end
endmodule : tb_voice_record_command_port

bind vrc_voice_port vrc_voice_port_assertions #(.OP_CYC(OP_CYC)) u_chk (.ref_clk(ref_clk),
	.rstn(rstn), .ext_standby_reset_n(ext_standby_reset_n), .cs_n(cs_n), .sck(sck),
	.serial_cmd_in(serial_cmd_in), .engine(engine), .serial_resp_out(serial_resp_out),
	.busy_n(busy_n), .capture_en(capture_en), .play_en(play_en), .beep(beep));
